// file: npr_pkg.sv
// Constants for the flash protection and option register block
package npr_pkg;
    localparam logic [3:0] OFS_PFLASH_PROT  = 4'h8;
    localparam logic [3:0] OFS_EEPROM_PROT  = 4'h9;
    localparam logic [3:0] OFS_OPTION       = 4'ha;
    localparam logic [3:0] OFS_FACT_RSVD    = 4'hb;
    localparam logic [3:0] OFS_IRQ_STATUS   = 4'hc;
    localparam logic [3:0] OFS_IRQ_MASK     = 4'hd;
    localparam int POS_OP_EN     = 7;
    localparam int POS_RNV6      = 6;
    localparam int POS_HI_DIS    = 5;
    localparam int POS_LO_DIS    = 2;
    localparam int POS_EE_DIS    = 7;
    localparam logic [7:0] PFLASH_PROT_FAILSAFE = 8'h7f;
    localparam logic [7:0] EEPROM_PROT_FAILSAFE = 8'h0f;
    localparam logic [7:0] OPTION_FAILSAFE      = 8'hff;
    localparam logic [7:0] EEPROM_PROT_MASK     = 8'h8f;
    localparam logic [15:0] EE_SECTOR_BYTES     = 16'h0020;
    localparam logic [15:0] EE_SIZE_BYTES       = 16'h1000;
    typedef enum logic [1:0] {
        NPR_LOAD  = 2'b00,
        NPR_WAIT  = 2'b01,
        NPR_READY = 2'b10
    } npr_state_t;
endpackage

// file: npr_prot_regs.sv
// Flash protection, option and reserved registers with a Wishbone slave
`timescale 1ns/1ns
`default_nettype none
module npr_prot_regs (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        special_mode,
    input  wire logic        cfg_valid,
    input  wire logic [7:0]  cfg_pflash_prot,
    input  wire logic [7:0]  cfg_eeprom_prot,
    input  wire logic [7:0]  cfg_option,
    input  wire logic        cfg_double_fault,
    input  wire logic        ee_req,
    input  wire logic        ee_erase_block,
    input  wire logic [15:0] ee_addr,
    output logic             ee_grant,
    output logic             protect_violation_flag,
    output logic             cfg_done,
    output logic [7:0]       pflash_protect_reg,
    output logic [7:0]       eeprom_protect_reg,
    output logic [7:0]       option_reg,
    output logic             irq
);
    import npr_pkg::*;

    npr_state_t state;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic       wr;
    logic       rd_cyc;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic       ee_viol;

    assign idx   = wb_adr_i[5:2];
    assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_cyc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbyte = wb_dat_i[7:0];

    // Scenario: op enable, high disable, low disable
    function automatic logic [2:0] scen(input logic [7:0] v);
        scen = {v[POS_OP_EN], v[POS_HI_DIS], v[POS_LO_DIS]};
    endfunction

    function automatic logic allowed(input logic [2:0] f, input logic [2:0] t);
        logic [7:0] row;
        row = 8'h00;
        case (f) // Bit t set when scenario t may follow f
            3'd0:    row = 8'h0f;
            3'd1:    row = 8'h0a;
            3'd2:    row = 8'h0c;
            3'd3:    row = 8'h08;
            3'd4:    row = 8'h18;
            3'd5:    row = 8'h3c;
            3'd6:    row = 8'h5a;
            3'd7:    row = 8'hff;
            default: row = 8'h00;
        endcase
        allowed = row[t];
    endfunction

    // Size fields only take new bits while their range is disabled
    function automatic logic [7:0] pf_next(input logic [7:0] cur, input logic [7:0] w);
        logic [7:0] n;
        n = w;
        n[POS_RNV6] = cur[POS_RNV6];
        if (!cur[POS_HI_DIS]) begin
            n[4:3] = cur[4:3];
        end
        if (!cur[POS_LO_DIS]) begin
            n[1:0] = cur[1:0];
        end
        pf_next = n;
    endfunction

    logic [7:0] next_pf;
    logic [7:0] next_ee;
    assign next_pf = pf_next(pflash_protect_reg, wbyte);
    assign next_ee = wbyte & EEPROM_PROT_MASK;

    logic ee_ok;
    always_comb begin
        ee_ok = 1'b1;
        if (!special_mode) begin
            // Disable may only go 1 to 0, size must grow while enabled
            if (next_ee[POS_EE_DIS] && !eeprom_protect_reg[POS_EE_DIS]) begin
                ee_ok = 1'b0;
            end else if (!eeprom_protect_reg[POS_EE_DIS] &&
                         next_ee[3:0] <= eeprom_protect_reg[3:0]) begin
                ee_ok = 1'b0;
            end
        end
    end

    // Load sequence: wait for the config fetch, then unlock software writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= NPR_LOAD;
        end else begin
            case (state)
                NPR_LOAD:  state <= NPR_WAIT;
                NPR_WAIT:  if (cfg_valid) state <= NPR_READY;
                NPR_READY: state <= NPR_READY;
                default:   state <= NPR_LOAD;
            endcase
        end
    end
    assign cfg_done = (state == NPR_READY);

    // Fail-safe values stand until the fetch completes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pflash_protect_reg <= PFLASH_PROT_FAILSAFE;
        end else if (state == NPR_WAIT && cfg_valid) begin
            pflash_protect_reg <= cfg_double_fault ? PFLASH_PROT_FAILSAFE : cfg_pflash_prot;
        end else if (cfg_done && wr && idx == OFS_PFLASH_PROT) begin
            if (special_mode || allowed(scen(pflash_protect_reg), scen(next_pf))) begin
                pflash_protect_reg <= next_pf;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            eeprom_protect_reg <= EEPROM_PROT_FAILSAFE;
        end else if (state == NPR_WAIT && cfg_valid) begin
            eeprom_protect_reg <= cfg_double_fault ? EEPROM_PROT_FAILSAFE
                                                   : (cfg_eeprom_prot & EEPROM_PROT_MASK);
        end else if (cfg_done && wr && idx == OFS_EEPROM_PROT && ee_ok) begin
            eeprom_protect_reg <= next_ee;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            option_reg <= OPTION_FAILSAFE;
        end else if (state == NPR_WAIT && cfg_valid) begin
            option_reg <= cfg_double_fault ? OPTION_FAILSAFE : cfg_option;
        end
    end

    // Protected range covers 32 bytes per size step from the eeprom base
    logic [15:0] ee_limit;
    logic        ee_prot_on;
    assign ee_prot_on = !eeprom_protect_reg[POS_EE_DIS];
    // Widen before the add so size 1111 gives 512 bytes instead of wrapping to zero
    assign ee_limit = EE_SECTOR_BYTES * ({12'h000, eeprom_protect_reg[3:0]} + 16'h0001);
    assign ee_viol = ee_req && ee_prot_on && (ee_erase_block || ee_addr < ee_limit);
    assign ee_grant = ee_req && !ee_viol && cfg_done;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            protect_violation_flag <= 1'b0;
        end else if (ee_viol) begin
            protect_violation_flag <= 1'b1;
        end else if (wr && idx == OFS_IRQ_STATUS && wbyte[0]) begin
            protect_violation_flag <= 1'b0;
        end
    end

    // Status bits: set wins over write-one-to-clear
    logic [1:0] irq_evt;
    assign irq_evt = {wr && idx == OFS_PFLASH_PROT && cfg_done && !special_mode &&
                      !allowed(scen(pflash_protect_reg), scen(next_pf)), ee_viol};
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= 2'b00;
        end else if (wr && idx == OFS_IRQ_STATUS) begin
            irq_status <= (irq_status & ~wbyte[1:0]) | irq_evt;
        end else begin
            irq_status <= irq_status | irq_evt;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= 2'b00;
        end else if (wr && idx == OFS_IRQ_MASK) begin
            irq_mask <= wbyte[1:0];
        end
    end
    assign irq = |(irq_status & irq_mask);

    // One-wait-state slave; unmapped reads return zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= rd_cyc;
            case (idx)
                OFS_PFLASH_PROT: wb_dat_o <= {24'h000000, pflash_protect_reg};
                OFS_EEPROM_PROT: wb_dat_o <= {24'h000000, eeprom_protect_reg};
                OFS_OPTION:      wb_dat_o <= {24'h000000, option_reg};
                OFS_FACT_RSVD:   wb_dat_o <= 32'h0000_0000;
                OFS_IRQ_STATUS:  wb_dat_o <= {30'h0, irq_status};
                OFS_IRQ_MASK:    wb_dat_o <= {30'h0, irq_mask};
                default:         wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    pf_ignore_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_PFLASH_PROT && !special_mode &&
         !allowed(scen(pflash_protect_reg), scen(next_pf)))
        |=> $stable(pflash_protect_reg))
        else $error("disallowed scenario write changed register");
    scen_to_three_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && scen(pflash_protect_reg) == 3'd3 && !special_mode)
        |=> scen(pflash_protect_reg) == 3'd3)
        else $error("full protection was lowered");
    ee_noloss_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && !special_mode && !eeprom_protect_reg[POS_EE_DIS])
        |=> !eeprom_protect_reg[POS_EE_DIS])
        else $error("eeprom protection removed in normal mode");
    ee_fail_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == NPR_WAIT && cfg_valid && cfg_double_fault)
        |=> eeprom_protect_reg == EEPROM_PROT_FAILSAFE && option_reg == OPTION_FAILSAFE)
        else $error("fail-safe values not loaded");
    ee_viol_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ee_req && !eeprom_protect_reg[POS_EE_DIS] && ee_addr < EE_SECTOR_BYTES)
        |-> !ee_grant ##1 protect_violation_flag)
        else $error("protected access granted");
    ee_open_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eeprom_protect_reg[POS_EE_DIS] && ee_req && cfg_done) |-> ee_grant)
        else $error("disabled protection refused access");
    opt_ro_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cfg_done |=> $stable(option_reg))
        else $error("option register changed after load");
    rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rd_cyc && idx == OFS_FACT_RSVD) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("reserved register read nonzero");
    ack_once_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wb_ack_o
        |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    // Scenario register: writes checked only after the load, while software owns it; reads checked at any time
    pf_take_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_PFLASH_PROT && !special_mode &&
         allowed(scen(pflash_protect_reg), scen(next_pf)))
        |=> pflash_protect_reg == $past(next_pf))
        else $error("allowed scenario write was dropped");
    pf_special_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_PFLASH_PROT && special_mode)
        |=> pflash_protect_reg == $past(next_pf))
        else $error("special mode scenario write was dropped");
    pf_trans_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && !special_mode)
        |=> allowed(scen($past(pflash_protect_reg)), scen(pflash_protect_reg)))
        else $error("scenario moved along a forbidden transition");
    pf_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && !(wr && idx == OFS_PFLASH_PROT))
        |=> $stable(pflash_protect_reg))
        else $error("scenario register changed without a write");
    pf_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rd_cyc && idx == OFS_PFLASH_PROT)
        |=> wb_ack_o && wb_dat_o == {24'h000000, $past(pflash_protect_reg)})
        else $error("scenario read differs from register in force");
    pf_hi_size_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_PFLASH_PROT && !pflash_protect_reg[POS_HI_DIS])
        |=> $stable(pflash_protect_reg[4:3]))
        else $error("high range size written while range enabled");
    pf_lo_size_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_PFLASH_PROT && !pflash_protect_reg[POS_LO_DIS])
        |=> $stable(pflash_protect_reg[1:0]))
        else $error("low range size written while range enabled");

    // Eeprom protection register: add-only in normal mode, free in special mode
    ee_special_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_EEPROM_PROT && special_mode)
        |=> eeprom_protect_reg == $past(next_ee))
        else $error("special mode eeprom write was dropped");
    ee_grow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_EEPROM_PROT && !special_mode &&
         !eeprom_protect_reg[POS_EE_DIS] && next_ee[3:0] <= eeprom_protect_reg[3:0])
        |=> $stable(eeprom_protect_reg))
        else $error("eeprom size shrank or stayed in normal mode");
    ee_grow_ok_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_EEPROM_PROT && !special_mode && !next_ee[POS_EE_DIS] &&
         !eeprom_protect_reg[POS_EE_DIS] && next_ee[3:0] > eeprom_protect_reg[3:0])
        |=> eeprom_protect_reg == $past(next_ee))
        else $error("growing eeprom size was refused");
    ee_enable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && wr && idx == OFS_EEPROM_PROT && eeprom_protect_reg[POS_EE_DIS])
        |=> eeprom_protect_reg == $past(next_ee))
        else $error("write to unprotected eeprom register was refused");
    ee_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_done && !(wr && idx == OFS_EEPROM_PROT))
        |=> $stable(eeprom_protect_reg))
        else $error("eeprom protection changed without a write");
    ee_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rd_cyc && idx == OFS_EEPROM_PROT)
        |=> wb_ack_o && wb_dat_o == {24'h000000, $past(eeprom_protect_reg)})
        else $error("eeprom protection read differs from register");
    ee_rsvd_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cfg_done
        |-> eeprom_protect_reg[6:4] == 3'h0)
        else $error("reserved eeprom protection bits set");
    ee_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == NPR_WAIT && cfg_valid && !cfg_double_fault)
        |=> eeprom_protect_reg == ($past(cfg_eeprom_prot) & EEPROM_PROT_MASK))
        else $error("eeprom protection not loaded from config byte");
    done_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cfg_done
        |=> cfg_done)
        else $error("load sequence restarted without reset");

    // Option register: loaded once, never written
    opt_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == NPR_WAIT && cfg_valid && !cfg_double_fault)
        |=> option_reg == $past(cfg_option))
        else $error("option register not loaded from config byte");
    opt_fail_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == NPR_WAIT && cfg_valid && cfg_double_fault)
        |=> option_reg == OPTION_FAILSAFE)
        else $error("option register not all ones after fault");
    opt_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rd_cyc && idx == OFS_OPTION)
        |=> wb_ack_o && wb_dat_o == {24'h000000, $past(option_reg)})
        else $error("option read differs from register");

    // Range check written in sectors so it does not lean on the limit product
    blk_erase_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ee_req && ee_erase_block && !eeprom_protect_reg[POS_EE_DIS])
        |-> !ee_grant)
        else $error("block erase granted with protection on");
    ee_erase_open_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ee_req && ee_erase_block && cfg_done && eeprom_protect_reg[POS_EE_DIS])
        |-> ee_grant)
        else $error("block erase refused with protection off");
    ee_inside_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ee_req && !eeprom_protect_reg[POS_EE_DIS] && ee_addr[15:5] <= {7'h00, eeprom_protect_reg[3:0]})
        |-> !ee_grant)
        else $error("access inside protected range granted");
    ee_outside_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ee_req && cfg_done && !ee_erase_block && !eeprom_protect_reg[POS_EE_DIS] &&
         ee_addr[15:5] > {7'h00, eeprom_protect_reg[3:0]})
        |-> ee_grant)
        else $error("access beyond protected range refused");
    ee_dis_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        eeprom_protect_reg[POS_EE_DIS]
        |-> !ee_viol)
        else $error("violation raised with protection disabled");

    // Violation flag and interrupt
    viol_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ee_req && cfg_done && !ee_grant)
        |=> protect_violation_flag)
        else $error("refused access left no violation flag");
    viol_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (protect_violation_flag && !(wr && idx == OFS_IRQ_STATUS && wbyte[0]))
        |=> protect_violation_flag)
        else $error("violation flag dropped without a clear");
    viol_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (protect_violation_flag && wr && idx == OFS_IRQ_STATUS && wbyte[0] &&
         !ee_viol)
        |=> !protect_violation_flag)
        else $error("violation flag survived its clear");
    irq_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (protect_violation_flag && irq_mask[0])
        |-> irq)
        else $error("unmasked violation raised no interrupt");
    irq_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (irq_mask == 2'b00)
        |-> !irq)
        else $error("interrupt raised with all sources masked");
endmodule
`default_nettype wire

// file: npr_prot_regs_bench.sv
// Self-checking bench for the flash protection and option registers
`timescale 1ns/1ns
`default_nettype none
module npr_prot_regs_bench;
    import npr_pkg::*;
    localparam logic [63:0] ALLOWED = 64'hff5a_3c18_080c_0a0f;
    logic        core_clk, reset_n, cyc, stb, we, smode, cvalid, dfault;
    logic        ee_req, ee_blk, ack, grant, viol, done, irq;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  cp, ce, co, pf, ef, op, rd, d, e;
    logic [15:0] ee_addr, a, bound;
    logic [7:0]  ev [8] = '{8'h85, 8'h03, 8'h02, 8'h03, 8'h83, 8'h07, 8'h80, 8'h7f};
    logic [7:0]  ex [8] = '{8'h85, 8'h03, 8'h03, 8'h03, 8'h03, 8'h07, 8'h80, 8'h0f};
    int          fail_count, checks_done, cycles;
    npr_prot_regs dut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .special_mode(smode), .cfg_valid(cvalid), .cfg_pflash_prot(cp),
        .cfg_eeprom_prot(ce), .cfg_option(co), .cfg_double_fault(dfault), .ee_req(ee_req),
        .ee_erase_block(ee_blk), .ee_addr(ee_addr), .ee_grant(grant),
        .protect_violation_flag(viol), .cfg_done(done), .pflash_protect_reg(pf),
        .eeprom_protect_reg(ef), .option_reg(op), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk8(input logic [7:0] g, input logic [7:0] x);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk1(input logic g, input logic x);
        chk8({7'h0, g}, {7'h0, x});
    endtask
    // Classic cycle: request held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] v);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, v};
        @(posedge core_clk);
        while (ack !== 1'b1) @(posedge core_clk);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] idx, input logic [7:0] x);
        wb(1'b0, idx, 8'h00);
        chk8(rd, x);
    endtask
    task automatic do_reset(input logic df);
        cp <= 8'($urandom);
        ce <= 8'($urandom);
        co <= 8'($urandom);
        dfault <= df;
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 10 && done !== 1'b1; i++) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    function automatic logic [7:0] sc(input logic [2:0] s, input logic [7:0] r);
        return {s[2], r[6], s[1], r[4:3], s[0], r[1:0]};
    endfunction
    // Disabled protection grants all; otherwise the first 32*(size+1) bytes are locked
    function automatic logic ok_ee(input logic [7:0] p, input logic b, input logic [15:0] ad);
        return p[POS_EE_DIS] || (!b && ad >= EE_SECTOR_BYTES * ({12'h0, p[3:0]} + 16'h1));
    endfunction
    task automatic ee_try(input logic b, input logic [15:0] ad, input logic [7:0] p);
        @(posedge core_clk);
        ee_req <= 1'b1;
        ee_blk <= b;
        ee_addr <= ad;
        @(negedge core_clk);
        chk1(grant, ok_ee(p, b, ad));
        @(posedge core_clk);
        ee_req <= 1'b0;
        @(negedge core_clk);
        if (!ok_ee(p, b, ad)) chk1(viol, 1'b1);
    endtask
    initial begin
        {reset_n, cyc, stb, we, smode, dfault, ee_req, ee_blk} = '0;
        {adr, wdat, cp, ce, co, ee_addr, cycles, fail_count, checks_done} = '0;
        cvalid = 1'b1;
        void'($urandom(27292));
        do_reset(1'b0);
        chk1(done, 1'b1);
        chk8(ef, ce & EEPROM_PROT_MASK);
        chk8(op, co);
        wb(1'b1, OFS_OPTION, ~co);
        rdchk(OFS_OPTION, co);
        wb(1'b1, OFS_FACT_RSVD, 8'hff);
        rdchk(OFS_FACT_RSVD, 8'h00);
        wb(1'b1, 4'hf, 8'h5a);
        rdchk(4'hf, 8'h00);
        do_reset(1'b1);
        chk8(ef, EEPROM_PROT_FAILSAFE);
        chk8(op, OPTION_FAILSAFE);
        for (int f = 0; f < 8; f++) begin
            for (int t = 0; t < 8; t++) begin
                d = 8'($urandom);
                smode <= 1'b1;
                wb(1'b1, OFS_PFLASH_PROT, sc(3'(f), d));
                smode <= 1'b0;
                wb(1'b1, OFS_PFLASH_PROT, sc(3'(t), ~d));
                wb(1'b0, OFS_PFLASH_PROT, 8'h00);
                e = {5'h0, ALLOWED[f * 8 + t] ? 3'(t) : 3'(f)};
                chk8({5'h0, rd[7], rd[5], rd[2]}, e);
            end
        end
        wb(1'b0, OFS_IRQ_STATUS, 8'h00);
        chk1(rd[1], 1'b1);
        smode <= 1'b1;
        wb(1'b1, OFS_PFLASH_PROT, 8'h00);
        wb(1'b1, OFS_PFLASH_PROT, 8'h1b);
        wb(1'b0, OFS_PFLASH_PROT, 8'h00);
        chk8(rd & 8'hbf, 8'h00);
        wb(1'b1, OFS_PFLASH_PROT, 8'ha4);
        wb(1'b1, OFS_PFLASH_PROT, 8'hbf);
        wb(1'b0, OFS_PFLASH_PROT, 8'h00);
        chk8(rd & 8'hbf, 8'hbf);
        chk8(pf & 8'hbf, 8'hbf);
        for (int i = 0; i < 8; i++) begin
            smode <= (i == 0 || i > 5);
            wb(1'b1, OFS_EEPROM_PROT, ev[i]);
            rdchk(OFS_EEPROM_PROT, ex[i]);
        end
        // Mask left open so the violation flag also drives the interrupt
        wb(1'b1, OFS_IRQ_MASK, 8'h01);
        for (int i = 0; i < 24; i++) begin
            smode <= 1'b1;
            e = {1'($urandom % 4 == 0), 3'h0, 4'($urandom)};
            wb(1'b1, OFS_EEPROM_PROT, e);
            bound = EE_SECTOR_BYTES * ({12'h0, e[3:0]} + 16'h1);
            a = (i < 12) ? bound - 16'(i % 2) : 16'($urandom % 1024);
            ee_try(1'($urandom % 4 == 0), a, e);
        end
        wb(1'b1, OFS_IRQ_STATUS, 8'h03);
        @(negedge core_clk);
        chk1(viol, 1'b0);
        chk1(irq, 1'b0);
        wb(1'b1, OFS_EEPROM_PROT, 8'h00);
        ee_try(1'b0, 16'h0010, 8'h00);
        chk1(irq, 1'b1);
        wb(1'b1, OFS_IRQ_MASK, 8'h00);
        @(negedge core_clk);
        chk1(irq, 1'b0);
        rdchk(OFS_IRQ_STATUS, 8'h01);
        wb(1'b1, OFS_IRQ_STATUS, 8'h01);
        rdchk(OFS_IRQ_STATUS, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
